// *** core/asrp_ctrl.sv ***
// host-side controller driving a 16k x 4 asynchronous static memory
//
// Notes on behaviour
// - write: select and strobe low, data driven
// - read: select low, strobe high, memory drives
// - strobe stays high through every read
// - address valid no later than select
// - deselect before retention, wait read cycle
// - select held 13 ns before write end
`timescale 1ns/1ps
`include "asrp_defs.svh"

module asrp_ctrl #(
  parameter int ADDR_W = 14, // fourteen address lines
  parameter int DATA_W = 4   // four data lines
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic req_valid_in,                 // request strobe
  input wire logic req_write_in,                 // 1 write, 0 read
  input wire logic [ADDR_W-1:0] req_addr_in,     // word address
  input wire logic [DATA_W-1:0] req_wdata_in,    // write data
  input wire logic retain_req_in,                // ask for data retention
  output logic req_ready_out,                    // idle and may take request
  output logic rsp_valid_out,                    // read data valid pulse
  output logic [DATA_W-1:0] rsp_rdata_out,       // read data
  output logic retain_ok_out,                    // memory deselected for retention
  output logic [ADDR_W-1:0] mem_addr_out,        // address lines, low to high
  output logic mem_sel_n_out,                    // active-low select
  output logic mem_we_n_out,                     // active-low write strobe
  output logic [DATA_W-1:0] mem_dq_out,          // data lines, out value
  output logic mem_dq_oe_out,                    // data lines, drive enable
  input wire logic [DATA_W-1:0] mem_dq_in        // data lines, in value
);
  import asrp_pkg::*;

  localparam logic [3:0] RC_CYC = 4'(`ASRP_RC_CYC);
  localparam logic [3:0] WP_CYC = 4'(`ASRP_WP_CYC);
  localparam logic [3:0] HZ_CYC = 4'(`ASRP_HZ_CYC);

  // ----------------------------------------
  // state record
  // ----------------------------------------
  typedef struct packed {
    asrp_state_e st;            // sequencer state
    logic [3:0] cnt;            // cycle counter
    logic ready;                // request ready
    logic rsp_valid;            // read answer pulse
    logic [DATA_W-1:0] rdata;   // read answer data
    logic retain_ok;            // retention allowed
    logic [ADDR_W-1:0] addr;    // address pins
    logic sel_n;                // select pin
    logic we_n;                 // strobe pin
    logic [DATA_W-1:0] dq;      // data pin value
    logic dq_oe;                // data pin enable
  } asrp_regs_s;

  asrp_regs_s state_reg;
  asrp_regs_s state_next;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  // sequencer for read, write and retention
  always_comb
  begin
    state_next = state_reg;
    state_next.rsp_valid = 1'b0;
    unique case (state_reg.st)
      ASRP_IDLE:
      begin
        if (retain_req_in)
        begin
          state_next.sel_n = 1'b1;
          state_next.retain_ok = 1'b1;
          state_next.ready = 1'b0;
        end
        else if (state_reg.retain_ok)
        begin
          // wait one read cycle after return
          state_next.retain_ok = 1'b0;
          state_next.cnt = RC_CYC;
          state_next.st = ASRP_RECOV;
        end
        else if (req_valid_in)
        begin
          state_next.addr = req_addr_in;
          state_next.dq = req_wdata_in;
          state_next.ready = 1'b0;
          state_next.st = req_write_in ? ASRP_WSEL : ASRP_RSEL;
        end
      end
      ASRP_RSEL:
      begin
        state_next.sel_n = 1'b0;
        state_next.we_n = 1'b1;
        state_next.cnt = RC_CYC;
        state_next.st = ASRP_RWAIT;
      end
      ASRP_RWAIT:
      begin
        if (state_reg.cnt == 4'h1)
        begin
          state_next.rdata = mem_dq_in;
          state_next.rsp_valid = 1'b1;
          state_next.sel_n = 1'b1;
          state_next.ready = 1'b1;
          state_next.st = ASRP_IDLE;
        end
        else
        begin
          state_next.cnt = state_reg.cnt - 4'h1;
        end
      end
      ASRP_WSEL:
      begin
        state_next.sel_n = 1'b0;
        state_next.we_n = 1'b0;
        state_next.cnt = HZ_CYC + WP_CYC;
        state_next.st = ASRP_WSTRB;
      end
      ASRP_WSTRB:
      begin
        // drive data only after release time
        if (state_reg.cnt == WP_CYC + 4'h1)
        begin
          state_next.dq_oe = 1'b1;
        end
        if (state_reg.cnt == 4'h1)
        begin
          // strobe and select end the write together
          // data stays driven one more cycle as hold, memory already floats
          state_next.we_n = 1'b1;
          state_next.sel_n = 1'b1;
          state_next.st = ASRP_RECOV;
          state_next.cnt = 4'h1;
        end
        else
        begin
          state_next.cnt = state_reg.cnt - 4'h1;
        end
      end
      ASRP_RECOV:
      begin
        // release select and data, then ready
        state_next.sel_n = 1'b1;
        state_next.dq_oe = 1'b0;
        if (state_reg.cnt == 4'h1)
        begin
          state_next.ready = 1'b1;
          state_next.st = ASRP_IDLE;
        end
        else
        begin
          state_next.cnt = state_reg.cnt - 4'h1;
        end
      end
      default:
      begin
        state_next.st = ASRP_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // synchronous active-low reset
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= '{st: ASRP_IDLE, cnt: 4'h0, ready: 1'b1, rsp_valid: 1'b0, rdata: '0,
                     retain_ok: 1'b0, addr: '0, sel_n: 1'b1, we_n: 1'b1, dq: '0, dq_oe: 1'b0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flops
  assign req_ready_out = state_reg.ready;
  assign rsp_valid_out = state_reg.rsp_valid;
  assign rsp_rdata_out = state_reg.rdata;
  assign retain_ok_out = state_reg.retain_ok;
  assign mem_addr_out = state_reg.addr;
  assign mem_sel_n_out = state_reg.sel_n;
  assign mem_we_n_out = state_reg.we_n;
  assign mem_dq_out = state_reg.dq;
  assign mem_dq_oe_out = state_reg.dq_oe;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // strobe high in reads
  read_strobe_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (state_reg.st == ASRP_RWAIT) |-> state_reg.we_n)
    else $error("strobe low during read");
  // never drive against a reading memory
  write_drive_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    state_reg.dq_oe |-> (state_reg.sel_n || !state_reg.we_n))
    else $error("data driven while memory reads");
  write_data_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $rose(state_reg.we_n) |-> (state_reg.dq_oe && $past(state_reg.dq_oe)))
    else $error("write ended without data driven");
  addr_stable_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (!state_reg.sel_n && !$past(state_reg.sel_n)) |-> $stable(state_reg.addr))
    else $error("address moved while selected");
  sel_hold_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $rose(state_reg.we_n) |-> $past(!state_reg.sel_n))
    else $error("select dropped before write end");
  retain_desel_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    state_reg.retain_ok |-> state_reg.sel_n)
    else $error("selected during retention");
  read_answer_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (state_reg.st == ASRP_RSEL) |-> ##[1:3] state_reg.rsp_valid)
    else $error("read answer late");
endmodule : asrp_ctrl

// *** core/asrp_defs.svh ***
// timing constants for the static memory port controller
`ifndef ASRP_DEFS_SVH
`define ASRP_DEFS_SVH
// clock period in ns
`define ASRP_CLK_NS 100
// read cycle time, ns
`define ASRP_T_RC_NS 15
// chip enable to end of write, ns
`define ASRP_T_CW_NS 13
// write pulse width, ns
`define ASRP_T_WP_NS 13
// write enable to output in high z, ns
`define ASRP_T_HZWE_NS 10
// deselect margin before retention, ns
`define ASRP_T_CDR_NS 0
// derived cycle counts, least times round up, at least one
`define ASRP_RC_CYC ((`ASRP_T_RC_NS + `ASRP_CLK_NS - 1) / `ASRP_CLK_NS)
`define ASRP_CW_CYC ((`ASRP_T_CW_NS + `ASRP_CLK_NS - 1) / `ASRP_CLK_NS)
`define ASRP_WP_CYC ((`ASRP_T_WP_NS + `ASRP_CLK_NS - 1) / `ASRP_CLK_NS)
// bus turnaround after strobe fall before driving data
`define ASRP_HZ_CYC ((`ASRP_T_HZWE_NS + `ASRP_CLK_NS - 1) / `ASRP_CLK_NS)
`endif

// *** core/asrp_pkg.sv ***
// types for the static memory port controller
package asrp_pkg;
  // controller states, one-hot
  typedef enum logic [5:0] {
    ASRP_IDLE = 6'h01,
    ASRP_RSEL = 6'h02,
    ASRP_RWAIT = 6'h04,
    ASRP_WSEL = 6'h08,
    ASRP_WSTRB = 6'h10,
    ASRP_RECOV = 6'h20
  } asrp_state_e;
endpackage : asrp_pkg

// *** sim/asrp_mem_model.sv ***
// behavioural 16k x 4 static memory facing the controller
`timescale 1ns/1ps
module asrp_mem_model (
  input wire logic [13:0] addr_in,
  input wire logic sel_n_in,
  input wire logic we_n_in,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic dq_oe_out
);
  logic [3:0] cells [0:16383];
  // store while selected with strobe low; last value before either edge stays
  always @*
    if (!sel_n_in && !we_n_in)
      cells[addr_in] = dq_in;
  // drive only when selected with strobe high
  assign dq_oe_out = !sel_n_in && we_n_in;
  assign dq_out = cells[addr_in];
endmodule : asrp_mem_model

// *** sim/async_static_ram_port_tb_top.sv ***
// self-checking bench for the static memory port controller
`timescale 1ns/1ps
module async_static_ram_port_tb_top;
  logic clk = 0, rstn = 0, valid = 0, wr = 0, retain = 0;
  logic [13:0] addr = 0;
  logic [3:0] wdata = 0, rdata, cdq, mdq, dq_last = 0;
  logic ready, rsp, rok, sel_n, we_n, coe, moe, in_rd = 0;
  logic [13:0] maddr;
  wire [3:0] dq = coe ? cdq : moe ? mdq : ~dq_last;
  int errors = 0, comparisons = 0, cycles = 0, k, i;
  logic [3:0] ref_mem [int];
  asrp_ctrl DUT (.core_clk_in(clk), .rstn_in(rstn), .req_valid_in(valid), .req_write_in(wr),
    .req_addr_in(addr), .req_wdata_in(wdata), .retain_req_in(retain), .req_ready_out(ready),
    .rsp_valid_out(rsp), .rsp_rdata_out(rdata), .retain_ok_out(rok), .mem_addr_out(maddr),
    .mem_sel_n_out(sel_n), .mem_we_n_out(we_n), .mem_dq_out(cdq), .mem_dq_oe_out(coe), .mem_dq_in(dq));
  asrp_mem_model mem (.addr_in(maddr), .sel_n_in(sel_n), .we_n_in(we_n), .dq_in(dq), .dq_out(mdq),
    .dq_oe_out(moe));
  initial forever #50 clk = ~clk;
  // released lines show the inverse of their last level
  always @(posedge clk) dq_last <= dq;
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic conclude;
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  // pin monitor at the falling edge, where pins are settled
  always @(negedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      conclude();
    end
    if (rstn && $fell(sel_n))
      check("addr_before_sel", maddr, $past(maddr));
    if (in_rd && !sel_n)
      check("we_n_in_read", we_n, 1);
    if (sel_n && !we_n)
      check("write_needs_sel", sel_n, 0);
  end
  // one request, waiting for the idle flag and checking the reply timing
  task automatic req(input logic w, input logic [13:0] a, input logic [3:0] d);
    k = 0;
    while (!ready && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    valid = 1;
    in_rd = !w;
    wr = w;
    addr = a;
    wdata = d;
    @(negedge clk);
    valid = 0;
    k = 0;
    while (!(w ? ready : rsp) && k < 9)
    begin
      @(negedge clk);
      k++;
    end
    in_rd = 0;
    check(w ? "write_time" : "read_time", k, w ? 4 : 2);
    if (w)
      ref_mem[a] = d;
    else
      check("read_data", rdata, ref_mem[a]);
  endtask : req
  initial
  begin
    void'($urandom(80810));
    repeat (4) @(negedge clk);
    rstn = 1;
    check("idle_pins", {ready, sel_n, we_n, coe, rok}, 5'h1C);
    // both ends of the address range
    req(1, 14'h0000, 4'hA);
    req(1, 14'h3FFF, 4'h5);
    req(0, 14'h3FFF, 0);
    req(0, 14'h0000, 0);
    // random traffic, reads only of written words
    for (i = 0; i < 60; i++)
    begin
      addr = 14'($urandom);
      if (($urandom % 2) == 1 || !ref_mem.exists(addr))
        req(1, addr, 4'($urandom));
      else
        req(0, addr, 0);
    end
    // retention: a write offered meanwhile must be refused
    retain = 1;
    valid = 1;
    wr = 1;
    addr = 0;
    wdata = 4'h3;
    repeat (2) @(negedge clk);
    check("retain_pins", {rok, sel_n, ready}, 3'h6);
    retain = 0;
    valid = 0;
    req(0, 14'h0000, 0);
    conclude();
  end
endmodule : async_static_ram_port_tb_top
